//--- src/cbs_pkg.sv
// Constants, types and behaviour summary for the code bank select block
// Overview of operation
// [R1] User flash split into 128-byte sectors
// [R2] Boot block may overlay low 8 kB
// [R3] Bit 1 soft restart, bit 0 bank choice
// [R4] Both bits zero: low region from boot
// [R5] Fetches above 1FFFH always from user block
// [R6] Boot reachable only while soft restart clear
// [R7] Software keeps bank choice while running low code
// [R8] Power-on reset forces bits to 00
// [R9] External reset acts like power-on reset
// [R10] Reset pin held for start-up plus two cycles
// [R11] Power-up flag set, cleared only by software
// [R12] Autobaud timeout after 400 ms hands to user
// [R13] Successful autobaud stays in programming mode
// [R14] Timeout with emulation flag enters emulation mode
// [R15] Hand-over by software reset, restart bit stays
// [R16] Reset keeps RAM, power-up contents undefined
// [R17] Reset sequence weakly pulls port pins high
// [R18] Unimplemented bits: read undefined, write zeros
// [R19] Restart bit rising forces 10 and restart
// [R20] Watchdog or brownout clears only bank choice
// [R21] Bank decision made per fetch from current bits
package cbs_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned AUTOBAUD_MS = 400;
  localparam int unsigned AUTOBAUD_CYC = AUTOBAUD_MS * (CLK_HZ / 1000);
  localparam int unsigned MACH_CLKS = 12;
  localparam int unsigned PULLUP_HOLD_CYC = 2 * MACH_CLKS;
  localparam logic [15:0] LOW_REGION_TOP = 16'h1FFF;
  localparam int unsigned SECTOR_LSB = 7;
  localparam logic [15:0] FLASH_CFG_OFS = 16'h0000;
  localparam logic [15:0] PWR_CTL_OFS = 16'h0004;
  localparam logic [15:0] BOOT_STAT_OFS = 16'h0008;
  localparam logic [3:0] RAM_PAGE = 4'h1;
  localparam int unsigned RAM_WORDS = 1024;
  localparam int unsigned BANK_CHOICE_BIT = 0;
  localparam int unsigned SOFT_RESTART_BIT = 1;
  localparam int unsigned POWER_UP_BIT = 4;
  localparam logic [1:0] CFG_RST_POR = 2'h0;
  localparam logic [1:0] CFG_RST_SOFT = 2'h2;
  localparam logic [1:0] BUS_IDLE = 2'h0;
  localparam logic [1:0] BUS_LOOK = 2'h1;
  localparam logic [1:0] BUS_ACK = 2'h2;

  typedef enum logic [1:0] {
    BT_AUTOBAUD = 2'b00,
    BT_ISP = 2'b01,
    BT_EMUL = 2'b10,
    BT_USER = 2'b11
  } cbs_boot_e;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } cbs_fetch_req_s;

  typedef struct packed {
    logic valid;
    logic boot_blk;
    logic [15:0] addr;
    logic [8:0] sector;
  } cbs_fetch_rsp_s;
endpackage

//--- src/cbs_ram.sv
// On-chip data RAM, no reset so contents survive system resets
`timescale 1ns/1ps
module cbs_ram import cbs_pkg::*; (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem_ff [RAM_WORDS];
  logic [7:0] rdata_ff;

  // No reset on purpose: a running reset must not disturb data
  always_ff @(posedge sys_clk) begin // see [R16]
    if (we) begin
      mem_ff[addr] <= wdata;
    end
    rdata_ff <= mem_ff[addr];
  end

  assign rdata = rdata_ff;
endmodule

//--- src/cbs_top.sv
// Code bank select, reset flags, boot sequencer and register slave
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module cbs_top import cbs_pkg::*; #(
  parameter int unsigned AUTOBAUD_CYC_P = AUTOBAUD_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire cbs_fetch_req_s fetch_req,
  output cbs_fetch_rsp_s fetch_rsp,
  input wire logic wdt_rst_pulse,
  input wire logic bor_rst_pulse,
  input wire logic autobaud_ok,
  input wire logic emulation_flag,
  output logic isp_mode,
  output logic emul_mode,
  output logic core_restart,
  output logic port_pullup,
  output logic soft_restart_flag,
  output logic bank_choice
);
  logic rst_meta_ff;
  logic rst_sync_n;

  // Async assert, synchronous release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_n <= rst_meta_ff;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_n);

  // Bus slave
  logic [1:0] bus_ph_ff;
  logic [1:0] nxt_bus_ph;
  logic wait_ff;
  logic nxt_wait;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [7:0] ram_rdata;
  logic ram_hit;
  logic commit_wr;
  logic ram_we;

  assign ram_hit = avs_address[15:12] == RAM_PAGE;
  assign commit_wr = (bus_ph_ff == BUS_ACK) && avs_write;
  assign ram_we = commit_wr && ram_hit;

  cbs_ram u_ram (
    .sys_clk(sys_clk),
    .we(ram_we),
    .addr(avs_address[11:2]),
    .wdata(avs_writedata[7:0]),
    .rdata(ram_rdata)
  );

  logic [1:0] cfg_ff;
  logic [1:0] nxt_cfg;
  logic power_up_ff;
  logic nxt_power_up;
  cbs_boot_e boot_ff;
  cbs_boot_e nxt_boot;
  // Mode outputs get their own flops so the pins never see decode glitches
  logic isp_ff;
  logic emul_ff;

  always_comb begin
    nxt_bus_ph = bus_ph_ff;
    nxt_wait = wait_ff;
    nxt_rdata = rdata_ff;
    unique case (bus_ph_ff)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_bus_ph = BUS_LOOK;
        end
      end
      BUS_LOOK: begin
        nxt_bus_ph = BUS_ACK;
        nxt_wait = 1'b0;
        // Unimplemented bits read as zero, never as undefined values
        nxt_rdata = 32'h0000_0000; // see [R18]
        if (avs_read) begin
          if (ram_hit) begin
            nxt_rdata = {24'h00_0000, ram_rdata};
          end else if (avs_address == FLASH_CFG_OFS) begin
            nxt_rdata = {30'h0000_0000, cfg_ff};
          end else if (avs_address == PWR_CTL_OFS) begin
            nxt_rdata[POWER_UP_BIT] = power_up_ff;
          end else if (avs_address == BOOT_STAT_OFS) begin
            nxt_rdata = {30'h0000_0000, boot_ff};
          end
        end
      end
      BUS_ACK: begin
        nxt_bus_ph = BUS_IDLE;
        nxt_wait = 1'b1;
      end
      default: begin
        nxt_bus_ph = BUS_IDLE;
        nxt_wait = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_ph_ff <= BUS_IDLE;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      bus_ph_ff <= nxt_bus_ph;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  sequence s_bus_req;
    (avs_read || avs_write) && bus_ph_ff == BUS_IDLE;
  endsequence
  sequence s_bus_ans;
    wait_ff ##1 !wait_ff ##1 wait_ff;
  endsequence
  a_bus_answer: assert property (s_bus_req |=> s_bus_ans)
    else $error("bus answer not in third cycle");

  // Boot sequencer stands in for the boot code after power-on
  logic [23:0] ab_cnt_ff;
  logic [23:0] nxt_ab_cnt;
  logic restart_ff;
  logic nxt_restart;
  logic boot_soft;
  logic ab_done;

  assign ab_done = ab_cnt_ff == 24'(AUTOBAUD_CYC_P - 1);

  always_comb begin
    nxt_boot = boot_ff;
    nxt_ab_cnt = ab_cnt_ff;
    boot_soft = 1'b0;
    unique case (boot_ff)
      BT_AUTOBAUD: begin
        nxt_ab_cnt = ab_cnt_ff + 24'h00_0001;
        if (autobaud_ok) begin
          nxt_boot = BT_ISP; // see [R13]
        end else if (ab_done) begin
          if (emulation_flag) begin
            nxt_boot = BT_EMUL; // see [R14]
          end else begin
            nxt_boot = BT_USER; // see [R12]
            boot_soft = 1'b1; // see [R15]
          end
        end
      end
      BT_ISP, BT_EMUL, BT_USER: begin
        nxt_boot = boot_ff;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      boot_ff <= BT_AUTOBAUD;
      ab_cnt_ff <= 24'h00_0000;
      isp_ff <= 1'b0;
      emul_ff <= 1'b0;
    end else begin
      boot_ff <= nxt_boot;
      ab_cnt_ff <= nxt_ab_cnt;
      isp_ff <= nxt_boot == BT_ISP; // see [R13]
      emul_ff <= nxt_boot == BT_EMUL; // see [R14]
    end
  end

  a_boot_timeout: assert property (boot_ff == BT_AUTOBAUD && ab_done && !autobaud_ok && !emulation_flag
    |=> boot_ff == BT_USER && restart_ff && cfg_ff == CFG_RST_SOFT) // see [R12] [R15]
    else $error("autobaud timeout did not hand over");
  a_isp_stays: assert property (boot_ff == BT_ISP |=> boot_ff == BT_ISP) // see [R13]
    else $error("programming mode left");
  a_emul_entry: assert property (boot_ff == BT_AUTOBAUD && ab_done && !autobaud_ok && emulation_flag
    |=> boot_ff == BT_EMUL && !restart_ff) // see [R14]
    else $error("emulation mode not entered");

  // Flash configuration and power control bits
  logic cfg_wr;
  logic pwr_wr;
  logic sw_soft;

  assign cfg_wr = commit_wr && avs_address == FLASH_CFG_OFS;
  assign pwr_wr = commit_wr && avs_address == PWR_CTL_OFS;
  assign sw_soft = cfg_wr && avs_writedata[SOFT_RESTART_BIT] && !cfg_ff[SOFT_RESTART_BIT];

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_power_up = power_up_ff;
    nxt_restart = 1'b0;
    // Hardware resets outrank any flash configuration write in the same cycle
    if (wdt_rst_pulse || bor_rst_pulse) begin
      nxt_cfg[BANK_CHOICE_BIT] = 1'b0; // see [R20]
    end else if (boot_soft || sw_soft) begin
      nxt_cfg = CFG_RST_SOFT; // see [R19]
      nxt_restart = 1'b1;
    end else if (cfg_wr) begin
      // Software must not drop bank choice while running low code
      nxt_cfg = avs_writedata[1:0]; // see [R3] [R7]
    end
    if (pwr_wr && !avs_writedata[POWER_UP_BIT]) begin
      nxt_power_up = 1'b0; // see [R11]
    end
  end

  // Pin reset is the power-on reset, so both land on the same values
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_ff <= CFG_RST_POR; // see [R8] [R9]
      power_up_ff <= 1'b1; // see [R11]
      restart_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      power_up_ff <= nxt_power_up;
      restart_ff <= nxt_restart;
    end
  end

  a_por_bits: assert property ($rose(rst_sync_n) |-> cfg_ff == CFG_RST_POR && power_up_ff) // see [R8] [R9]
    else $error("reset did not force boot mapping");
  a_soft_reset: assert property (sw_soft && !wdt_rst_pulse && !bor_rst_pulse
    |=> cfg_ff == CFG_RST_SOFT && restart_ff ##1 !restart_ff) // see [R19]
    else $error("soft reset not one pulse with bits 10");
  a_wdt_bits: assert property (wdt_rst_pulse || bor_rst_pulse
    |=> !cfg_ff[BANK_CHOICE_BIT] && cfg_ff[SOFT_RESTART_BIT] == $past(cfg_ff[SOFT_RESTART_BIT])) // see [R20]
    else $error("watchdog or brownout changed restart bit");
  a_power_up_hold: assert property (power_up_ff && !pwr_wr |=> power_up_ff) // see [R11]
    else $error("power-up flag lost without clear");

  // Fetch decode, one answer per fetch from the bits of that cycle
  cbs_fetch_rsp_s rsp_ff;
  cbs_fetch_rsp_s nxt_rsp;

  always_comb begin
    nxt_rsp.valid = fetch_req.valid;
    nxt_rsp.addr = fetch_req.addr;
    nxt_rsp.sector = fetch_req.addr[15:SECTOR_LSB]; // see [R1]
    // Overlay only at or below the top of the low region and with both bits clear
    nxt_rsp.boot_blk = fetch_req.valid && fetch_req.addr <= LOW_REGION_TOP
      && cfg_ff == CFG_RST_POR; // see [R2] [R4] [R5] [R6] [R21]
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  a_boot_map: assert property (fetch_req.valid && fetch_req.addr <= LOW_REGION_TOP && cfg_ff == CFG_RST_POR
    |=> rsp_ff.valid && rsp_ff.boot_blk) // see [R4] [R21]
    else $error("low fetch not from boot block");
  a_user_low: assert property (fetch_req.valid && fetch_req.addr <= LOW_REGION_TOP && cfg_ff != CFG_RST_POR
    |=> rsp_ff.valid && !rsp_ff.boot_blk) // see [R4] [R6]
    else $error("low fetch not from user block");
  a_user_high: assert property (fetch_req.valid && fetch_req.addr > LOW_REGION_TOP
    |=> !rsp_ff.boot_blk && rsp_ff.addr == $past(fetch_req.addr)) // see [R5]
    else $error("high fetch from boot block");
  a_sector_idx: assert property (fetch_req.valid |=> rsp_ff.sector == $past(fetch_req.addr[15:7])) // see [R1]
    else $error("sector index wrong");

  // Weak pull-up held through reset and two machine cycles after it
  logic [4:0] pu_cnt_ff;
  logic [4:0] nxt_pu_cnt;
  logic pullup_ff;
  logic nxt_pullup;

  always_comb begin
    nxt_pu_cnt = pu_cnt_ff;
    if (pu_cnt_ff != 5'(PULLUP_HOLD_CYC)) begin
      nxt_pu_cnt = pu_cnt_ff + 5'h01;
    end
    nxt_pullup = nxt_pu_cnt != 5'(PULLUP_HOLD_CYC); // see [R17] [R10]
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pu_cnt_ff <= 5'h00;
      pullup_ff <= 1'b1;
    end else begin
      pu_cnt_ff <= nxt_pu_cnt;
      pullup_ff <= nxt_pullup;
    end
  end

  a_pullup_rel: assert property ($rose(rst_sync_n) |-> pullup_ff [*8]) // see [R17]
    else $error("pull-up dropped too early");

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign fetch_rsp = rsp_ff;
  assign isp_mode = isp_ff;
  assign emul_mode = emul_ff;
  assign core_restart = restart_ff;
  assign port_pullup = pullup_ff;
  assign soft_restart_flag = cfg_ff[SOFT_RESTART_BIT];
  assign bank_choice = cfg_ff[BANK_CHOICE_BIT];
endmodule

//--- verification/cbs_core_model.sv
// Processor core fetch model facing the code bank select block
`timescale 1ns/1ps
module cbs_core_model import cbs_pkg::*; (
  input wire cbs_fetch_rsp_s fetch_rsp,
  input wire logic sys_clk,
  output cbs_fetch_req_s fetch_req
);
  initial fetch_req = '0;
  // One fetch, answer taken in the next cycle; the released address is inverted so a stale one never matches
  // Bank choice is cleared by the bench only between fetches, by register write or reset pulse
  task automatic fetch(input logic [15:0] a, output cbs_fetch_rsp_s r);
    @(posedge sys_clk);
    fetch_req <= '{valid: 1'b1, addr: a};
    @(posedge sys_clk);
    fetch_req <= '{valid: 1'b0, addr: ~a};
    @(negedge sys_clk);
    r = fetch_rsp;
  endtask
endmodule

//--- verification/cbs_top_bench.sv
// Self-checking bench for the code bank select block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module cbs_top_bench import cbs_pkg::*;;
  localparam int unsigned AB = 50;
  logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, wdt, bor, ab_ok, emu;
  logic isp_mode, emul_mode, core_restart, port_pullup, soft_restart_flag, bank_choice;
  logic [15:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  cbs_fetch_req_s fetch_req;
  cbs_fetch_rsp_s fetch_rsp;
  int n_fail = 0;
  int n_tests = 0;

  cbs_top #(.AUTOBAUD_CYC_P(AB)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fetch_req(fetch_req), .fetch_rsp(fetch_rsp), .wdt_rst_pulse(wdt),
    .bor_rst_pulse(bor), .autobaud_ok(ab_ok), .emulation_flag(emu), .isp_mode(isp_mode),
    .emul_mode(emul_mode), .core_restart(core_restart), .port_pullup(port_pullup),
    .soft_restart_flag(soft_restart_flag), .bank_choice(bank_choice));
  cbs_core_model i_core (.fetch_rsp(fetch_rsp), .sys_clk(sys_clk), .fetch_req(fetch_req));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Request held until waitrequest is sampled low at a rising edge, released right after that edge
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      n_fail++;
      finish_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK("readdata", e, q)
  endtask

  // Bits change at the edge that ends a write, so look half a cycle later
  task automatic chk_cfg(input logic [1:0] e);
    @(negedge sys_clk);
    `CHK("cfg bits", e, {soft_restart_flag, bank_choice})
    rd(FLASH_CFG_OFS, {30'h0, e});
  endtask

  task automatic chkf(input logic [15:0] a, input logic eb);
    cbs_fetch_rsp_s r;
    i_core.fetch(a, r);
    `CHK("fetch valid", 1'b1, r.valid)
    `CHK("boot block", eb, r.boot_blk)
    `CHK("sector", a[15:7], r.sector)
    `CHK("fetch addr", a, r.addr)
  endtask

  // Held for 5 clock cycles, shorter than start-up plus two machine cycles (24 clocks)
  task automatic do_rst(input logic e);
    emu <= e;
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic pulse(input logic w);
    @(posedge sys_clk);
    if (w) wdt <= 1'b1;
    else bor <= 1'b1;
    @(posedge sys_clk);
    wdt <= 1'b0;
    bor <= 1'b0;
    @(negedge sys_clk);
  endtask

  initial begin
    int k;
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 16'h0000;
    avs_writedata = 32'h0000_0000;
    wdt = 1'b0;
    bor = 1'b0;
    ab_ok = 1'b0;
    emu = 1'b1;
    do_rst(1'b1);
    `CHK("pullup", 1'b1, port_pullup)
    chk_cfg(2'h0);
    rd(PWR_CTL_OFS, 32'h0000_0010);
    chkf(16'h1FFF, 1'b1);
    chkf(16'h2000, 1'b0);
    chkf(16'hFF80, 1'b0);
    repeat (80) @(posedge sys_clk);
    `CHK("pullup", 1'b0, port_pullup)
    `CHK("emul mode", 1'b1, emul_mode)
    `CHK("isp mode", 1'b0, isp_mode)
    bus(1'b1, 16'h1014, 32'h0000_00A5);
    bus(1'b1, FLASH_CFG_OFS, 32'h0000_0001);
    chkf(16'h0000, 1'b0);
    chkf(16'h2400, 1'b0);
    bus(1'b1, FLASH_CFG_OFS, 32'h0000_0000);
    chkf(16'h0000, 1'b1);
    bus(1'b1, FLASH_CFG_OFS, 32'h0000_0003);
    @(negedge sys_clk);
    `CHK("restart pulse", 1'b1, core_restart)
    chk_cfg(2'h2);
    chkf(16'h1000, 1'b0);
    bus(1'b1, FLASH_CFG_OFS, 32'h0000_0003);
    pulse(1'b1);
    chk_cfg(2'h2);
    bus(1'b1, FLASH_CFG_OFS, 32'h0000_0001);
    pulse(1'b0);
    chk_cfg(2'h0);
    bus(1'b1, PWR_CTL_OFS, 32'h0000_0000);
    rd(PWR_CTL_OFS, 32'h0000_0000);
    bus(1'b1, PWR_CTL_OFS, 32'h0000_0010);
    rd(PWR_CTL_OFS, 32'h0000_0000);
    rd(16'h0100, 32'h0000_0000);
    $display("test power-on and banking done");
    do_rst(1'b0);
    rd(PWR_CTL_OFS, 32'h0000_0010);
    rd(16'h1014, 32'h0000_00A5);
    @(posedge sys_clk);
    ab_ok <= 1'b1;
    @(posedge sys_clk);
    ab_ok <= 1'b0;
    repeat (80) @(posedge sys_clk);
    `CHK("isp mode", 1'b1, isp_mode)
    chk_cfg(2'h0);
    $display("test autobaud done");
    do_rst(1'b0);
    for (k = 0; k < 4 * AB; k++) begin
      @(negedge sys_clk);
      if (core_restart === 1'b1) break;
    end
    `CHK("restart pulse", 1'b1, core_restart)
    @(negedge sys_clk);
    `CHK("restart pulse", 1'b0, core_restart)
    `CHK("emul mode", 1'b0, emul_mode)
    chk_cfg(2'h2);
    chkf(16'h0000, 1'b0);
    $display("test hand-over done");
    finish_test();
  end
endmodule
